// >>> sci_device.sv
// device end: strap capture, serial control port sequencer, interrupt pin
// Contract
// [R1] straps sampled during reset, then frozen
// [R2] strap levels decode to parallel, serial, management
// [R3] unused selection pins tied by board
// [R4] interrupt low active, configurable high active
// [R5] chip select fall starts new sequence
// [R6] capture on rising, shift on falling
// [R7] chip select rise ends the sequence
// [R8] bytes of eight bits, msb first
// [R9] first byte is header, selects sequence
// [R10] headers 40, 48, 43 decoded
// [R11] headers 41, 49 decoded
// [R12] header bit 2 selects upper half
// [R13] non-interleaved never drives during input bytes
// [R14] interleaved drives data during next address
// [R15] management mode disables serial register access
// [R16] constant address uses auto-incrementing pointer
// [R17] write address ends read phase
// [R18] read data in slot after address
// [R19] output released when idle; partial byte dropped
// [R20] address msb gives read or write
`timescale 1ns/1ps
module sci_device
   import sci_pkg::*;
(
   input  wire logic       mclk_in,       // 40 MHz system clock
   input  wire logic       nrst_in,       // async reset, active low
   sci_if.device           link,          // serial control link
   input  wire logic       strap_wr_in,   // write strobe pin level
   input  wire logic       strap_rd_in,   // read strobe pin level
   input  wire logic       strap_cs_in,   // chip select pin level
   input  wire logic       strap_ale_in,  // address latch pin level
   input  wire logic       irq_pend_in,   // internal interrupt pending
   input  wire logic       irq_high_in,   // interrupt polarity high when set
   input  wire logic [7:0] rd_data_in,    // register read data
   output logic [1:0]      port_sel_out,  // chosen host interface
   output logic            irq_out,       // interrupt pin level
   output logic            wr_out,        // register write pulse
   output logic            rd_out,        // register read pulse
   output logic [7:0]      addr_out,      // register address
   output logic [7:0]      wr_data_out,   // register write data
   output logic            sdo_out_reg,   // serial output value mirror
   output logic            sdo_oe_n_out   // serial output enable mirror
);
   logic [1:0] sck_s_reg, cs_s_reg, sdi_s_reg;
   logic       sck_d_reg, cs_d_reg;
   port_sel_t  port_reg;
   logic       strap_done_reg;
   seq_t       seq_reg;
   logic       upper_reg, rd_phase_reg, have_addr_reg, addr_rd_reg, first_data_reg;
   logic [2:0] bit_reg;
   logic [7:0] shift_reg, out_reg;
   logic [4:0] ptr_reg;
   logic       oe_n_reg, pend_out_reg, sdo_reg;
   logic [3:0] strap_a_reg, strap_b_reg;
   logic       wr_reg, rd_reg;
   logic [7:0] addr_reg, wdat_reg;

   wire sck_rise  = sck_s_reg[1] & ~sck_d_reg;
   wire sck_fall  = ~sck_s_reg[1] & sck_d_reg;
   wire cs_fall   = ~cs_s_reg[1] & cs_d_reg;
   wire cs_low    = ~cs_s_reg[1];
   wire active    = cs_low & (port_reg == port_serial);
   wire [7:0] rx  = {shift_reg[6:0], sdi_s_reg[1]};
   wire byte_done = active & sck_rise & (bit_reg == bit_last);
   wire is_rd     = rx[dir_bit];
   wire [7:0] full_addr = {upper_reg, rx[6:0]};
   wire seq_il    = (seq_reg == seq_adad_il) | (seq_reg == seq_rdwr_il);
   wire st_wr     = strap_b_reg[3];
   wire st_rd     = strap_b_reg[2];
   wire st_cs     = strap_b_reg[1];
   wire st_ale    = strap_b_reg[0];
   // [R2] strap decode
   wire port_sel_t strap_dec = (st_wr & st_rd & st_cs) ? port_parallel :
                               (~st_wr & ~st_rd & st_cs & ~st_ale)
                               ? port_serial : (~st_cs & ~st_ale) ? port_mgmt
                               : port_none;

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sck_s_reg <= 2'h0; cs_s_reg <= 2'h3; sdi_s_reg <= 2'h0;
         sck_d_reg <= 1'b0; cs_d_reg <= 1'b1;
      end else begin
         sck_s_reg <= {sck_s_reg[0], link.sck};
         cs_s_reg  <= {cs_s_reg[0], link.cs_n};
         sdi_s_reg <= {sdi_s_reg[0], link.serial_data_in};
         sck_d_reg <= sck_s_reg[1];
         cs_d_reg  <= cs_s_reg[1];
      end
   end

   // straps are pins: two flops without reset, so they keep sampling in reset
   always_ff @(posedge mclk_in) begin
      strap_a_reg <= {strap_wr_in, strap_rd_in, strap_cs_in, strap_ale_in};
      strap_b_reg <= strap_a_reg;
   end

   // [R1] levels seen during reset frozen at release
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         strap_done_reg <= 1'b0;
         port_reg       <= port_none;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         port_reg       <= strap_dec;
      end
   end

   // [R4] polarity applied to pending request
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) irq_out <= 1'b1;
      else          irq_out <= irq_high_in ? irq_pend_in : ~irq_pend_in;
   end

   // sequencer; [R15] only serial strap enables it
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         seq_reg <= seq_header; bit_reg <= 3'h0; shift_reg <= 8'h00;
         upper_reg <= 1'b0; rd_phase_reg <= 1'b1; have_addr_reg <= 1'b0;
         addr_rd_reg <= 1'b0; first_data_reg <= 1'b0; ptr_reg <= 5'h00;
         out_reg <= 8'h00; pend_out_reg <= 1'b0;
         wr_reg <= 1'b0; rd_reg <= 1'b0; addr_reg <= 8'h00; wdat_reg <= 8'h00;
      end else begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         // [R5] [R7] [R19] frame edges reset state; partial byte dropped
         if (!active || cs_fall) begin
            seq_reg <= seq_header; bit_reg <= 3'h0; have_addr_reg <= 1'b0;
            rd_phase_reg <= 1'b1; pend_out_reg <= 1'b0;
         end else if (sck_rise) begin
            // [R6] [R8] capture msb first
            shift_reg <= rx;
            bit_reg   <= bit_reg + 3'h1;
            pend_out_reg <= 1'b0;
            if (byte_done) begin
               if (seq_reg == seq_header) begin
                  // [R9] [R10] [R11] [R12] header selects sequence and half
                  seq_reg   <= decode_header(rx);
                  upper_reg <= rx[half_bit];
               end else if (seq_reg == seq_const) begin
                  // [R16] pointer steps after each data byte
                  if (!have_addr_reg) begin
                     have_addr_reg <= 1'b1; addr_rd_reg <= is_rd;
                     ptr_reg <= 5'h00; first_data_reg <= 1'b1;
                     addr_reg <= full_addr; rd_reg <= is_rd;
                     out_reg <= rd_data_in; pend_out_reg <= is_rd;
                  end else begin
                     ptr_reg <= (ptr_reg == const_ptr_max) ? 5'h00 : ptr_reg + 5'h01;
                     // current entry first, pointer steps afterwards
                     addr_reg <= {addr_reg[7:5], ptr_reg};
                     if (addr_rd_reg) begin
                        rd_reg <= 1'b1; out_reg <= rd_data_in; pend_out_reg <= 1'b1;
                     end else begin
                        wr_reg <= 1'b1; wdat_reg <= rx;
                     end
                  end
               end else if (seq_reg != seq_bad) begin
                  // [R17] in read-write sequences a write address closes read phase for good
                  if (!rd_phase_reg || have_addr_reg && !addr_rd_reg && !seq_il) begin
                     if (have_addr_reg && !addr_rd_reg || !rd_phase_reg && have_addr_reg) begin
                        wr_reg <= 1'b1; wdat_reg <= rx;
                        have_addr_reg <= (seq_reg == seq_rdwr) | (seq_reg == seq_rdwr_il);
                     end else begin
                        have_addr_reg <= 1'b1; addr_rd_reg <= is_rd; addr_reg <= full_addr;
                     end
                  end else if (have_addr_reg && addr_rd_reg && !seq_il) begin
                     // read slot of non-interleaved mode just ended
                     have_addr_reg <= 1'b0;
                  end else begin
                     // [R20] direction from address msb
                     addr_reg <= full_addr;
                     addr_rd_reg <= is_rd;
                     have_addr_reg <= 1'b1;
                     if (is_rd) begin
                        // [R18] [R14] data in next slot
                        rd_reg <= 1'b1; out_reg <= rd_data_in; pend_out_reg <= 1'b1;
                        have_addr_reg <= ~seq_il;
                     end else if ((seq_reg == seq_rdwr) | (seq_reg == seq_rdwr_il)) begin
                        rd_phase_reg <= 1'b0;
                     end
                  end
               end
            end
         end
      end
   end

   // [R6] [R13] [R19] drive only in scheduled slot, change on falling edge
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         oe_n_reg <= 1'b1; sdo_reg <= 1'b0;
      end else if (!active) begin
         oe_n_reg <= 1'b1;
      end else if (sck_fall) begin
         if (bit_reg == 3'h0) begin
            oe_n_reg  <= ~pend_out_reg;
            sdo_reg   <= out_reg[byte_bits-1];
         end else begin
            sdo_reg   <= out_reg[byte_bits-1-bit_reg];
         end
      end
   end

   assign link.serial_data_out = sdo_reg;
   assign link.sdo_oe_n        = oe_n_reg;
   assign port_sel_out = port_reg;
   assign wr_out       = wr_reg;
   assign rd_out       = rd_reg;
   assign addr_out     = addr_reg;
   assign wr_data_out  = wdat_reg;
   assign sdo_out_reg  = sdo_reg;
   assign sdo_oe_n_out = oe_n_reg;
endmodule // sci_device

// >>> sci_pkg.sv
// shared constants for the serial control port and its strapping
package sci_pkg;
   localparam int          byte_bits     = 8;
   localparam logic [7:0]  hdr_mask_half = 8'hfb;  // header with half-select bit cleared
   localparam int          half_bit      = 2;
   localparam int          dir_bit       = 7;      // address byte: 1 read, 0 write
   localparam logic [7:0]  hdr_adad      = 8'h40;
   localparam logic [7:0]  hdr_adad_il   = 8'h48;
   localparam logic [7:0]  hdr_const     = 8'h43;
   localparam logic [7:0]  hdr_rdwr      = 8'h41;
   localparam logic [7:0]  hdr_rdwr_il   = 8'h49;
   localparam logic [4:0]  const_ptr_max = 5'h1f;
   localparam int          sck_half_div  = 4;      // host shift clock half period in mclk
   localparam logic [2:0]  bit_last      = 3'h7;

   typedef enum logic [1:0] {
      port_parallel = 2'b00,
      port_serial   = 2'b01,
      port_mgmt     = 2'b10,
      port_none     = 2'b11
   } port_sel_t;

   typedef enum logic [2:0] {
      seq_header   = 3'b000,
      seq_adad     = 3'b001,
      seq_adad_il  = 3'b010,
      seq_const    = 3'b011,
      seq_rdwr     = 3'b100,
      seq_rdwr_il  = 3'b101,
      seq_bad      = 3'b110
   } seq_t;

   // header to sequence type, half-select bit ignored
   function automatic seq_t decode_header(input logic [7:0] h);
      logic [7:0] b;
      b = h & hdr_mask_half;
      case (b)
         hdr_adad:    decode_header = seq_adad;
         hdr_adad_il: decode_header = seq_adad_il;
         hdr_const:   decode_header = seq_const;
         hdr_rdwr:    decode_header = seq_rdwr;
         hdr_rdwr_il: decode_header = seq_rdwr_il;
         default:     decode_header = seq_bad;
      endcase
   endfunction
endpackage

// >>> sci_if.sv
// serial control link between host master and device port
`timescale 1ns/1ps
interface sci_if;
   logic sck;         // shift clock from master
   logic cs_n;        // chip select, active low
   logic serial_data_in;   // master to device
   logic serial_data_out;  // device output value
   logic sdo_oe_n;         // device output enable, low drives
   modport device (input sck, cs_n, serial_data_in, output serial_data_out, sdo_oe_n);
   modport host   (output sck, cs_n, serial_data_in, input serial_data_out, sdo_oe_n);
endinterface

// >>> sci_host.sv
// host end: serial master driving byte-level transactions
`timescale 1ns/1ps
module sci_host
   import sci_pkg::*;
(
   input  wire logic       mclk_in,     // 40 MHz system clock
   input  wire logic       nrst_in,     // async reset, active low
   sci_if.host             link,        // serial control link
   input  wire logic       start_in,    // pulse: open frame
   input  wire logic       byte_in,     // pulse: send tx byte
   input  wire logic [7:0] tx_in,       // byte to send
   input  wire logic       stop_in,     // pulse: close frame
   output logic            busy_out,    // byte in flight
   output logic            done_out,    // pulse: byte finished
   output logic [7:0]      rx_out       // byte sampled from device
);
   logic [1:0] sdo_s_reg;
   logic       cs_reg, sck_reg, busy_reg, done_reg, sdi_reg;
   logic [7:0] tx_reg, rx_reg;
   logic [2:0] bit_reg;
   logic [2:0] div_reg;
   wire tick = (div_reg == 3'(sck_half_div - 1));

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) sdo_s_reg <= 2'h0;
      // released line reads high, as with a pull-up
      else          sdo_s_reg <= {sdo_s_reg[0], link.sdo_oe_n | link.serial_data_out};
   end

   // [R5] [R7] [R8] frame and shift msb first; data changed on falling sck
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cs_reg <= 1'b1; sck_reg <= 1'b0; busy_reg <= 1'b0; done_reg <= 1'b0;
         tx_reg <= 8'h00; rx_reg <= 8'h00; bit_reg <= 3'h0; div_reg <= 3'h0; sdi_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start_in && !busy_reg) cs_reg <= 1'b0;
         else if (stop_in && !busy_reg) cs_reg <= 1'b1;
         else if (byte_in && !busy_reg && !cs_reg) begin
            busy_reg <= 1'b1; tx_reg <= {tx_in[6:0], 1'b0}; sdi_reg <= tx_in[7];
            bit_reg <= 3'h0; div_reg <= 3'h0;
         end else if (busy_reg) begin
            div_reg <= tick ? 3'h0 : div_reg + 3'h1;
            if (tick) begin
               sck_reg <= ~sck_reg;
               // sample just before our fall: device data lags our fall by five edges
               if (sck_reg) begin
                  rx_reg  <= {rx_reg[6:0], sdo_s_reg[1]};
                  bit_reg <= bit_reg + 3'h1;
                  sdi_reg <= tx_reg[7];
                  tx_reg  <= {tx_reg[6:0], 1'b0};
                  if (bit_reg == bit_last) begin
                     busy_reg <= 1'b0; done_reg <= 1'b1;
                  end
               end
            end
         end
      end
   end

   assign link.cs_n           = cs_reg;
   assign link.sck            = sck_reg;
   assign link.serial_data_in = sdi_reg;
   assign busy_out = busy_reg;
   assign done_out = done_reg;
   assign rx_out   = rx_reg;
endmodule // sci_host

// >>> sci_link_properties.sv
// checker for the serial control link joining host and device ends
`timescale 1ns/1ps
module sci_link_properties (
   input wire logic mclk_in,         // system clock
   input wire logic nrst_in,         // async reset, active low
   input wire logic sck,             // shift clock
   input wire logic cs_n,            // chip select, active low
   input wire logic serial_data_in,  // master data
   input wire logic serial_data_out, // device data
   input wire logic sdo_oe_n         // device enable, low drives
);
   logic [9:0] rise_cnt_reg;

   // shift clock rises seen in the current frame
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) rise_cnt_reg <= 10'h000;
      else rise_cnt_reg <= cs_n ? 10'h000 : rise_cnt_reg + {9'h000, $rose(sck)};
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   a_oe_idle_off: assert property (cs_n [*8] |-> sdo_oe_n)
      else $error("device drives its data line outside a frame");
   // device output may lag the falling edge by its synchroniser
   a_shift_on_fall: assert property (
      (!sdo_oe_n && !$past(sdo_oe_n) && $changed(serial_data_out)) |-> (!sck || $rose(sck)))
      else $error("device data changed while shift clock high");
   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("shift clock active outside a frame");
   a_sdi_steady_high: assert property (sck |-> $stable(serial_data_in))
      else $error("master data changed while shift clock high");
   a_sck_high_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
      else $error("shift clock high phase not four cycles");
   a_cs_fall_quiet: assert property ($fell(cs_n) |-> !sck [*4])
      else $error("shift clock rose too soon after frame start");
   a_whole_bytes: assert property ($rose(cs_n) |-> rise_cnt_reg[2:0] == 3'h0)
      else $error("frame closed on a partial byte");
   a_no_early_drive: assert property ((!sdo_oe_n && !cs_n) |-> rise_cnt_reg >= 10'h010)
      else $error("device drove data during header or address byte");
endmodule // sci_link_properties

// >>> tb_serial_host_register_port.sv
// bench: host and device ends joined over the serial link, byte-level tests
`timescale 1ns/1ps
module tb_serial_host_register_port;
   import sci_pkg::*;
   logic       mclk_in = 1'b0, nrst_in = 1'b0, irq_pend_in = 1'b0, irq_high_in = 1'b0;
   logic       start_in = 1'b0, byte_in = 1'b0, stop_in = 1'b0;
   logic [3:0] strap = 4'h0;  // wr, rd, cs, ale levels
   logic [7:0] rd_data_in = 8'hc3, tx_in = 8'h00;
   logic [1:0] port_sel_out;
   logic       irq_out, wr_out, rd_out, busy_out, done_out, oe_n_mon;
   logic [7:0] addr_out, wr_data_out, rx_out, last_wa, last_wd, last_ra;
   logic [7:0] tx_q[$], rx_q[$];
   int         wr_cnt = 0, rd_cnt = 0, miscompares = 0, cmp_count = 0, cyc = 0;

   sci_if link ();
   sci_device i_sci_device (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(link.device),
      .strap_wr_in(strap[3]), .strap_rd_in(strap[2]), .strap_cs_in(strap[1]),
      .strap_ale_in(strap[0]), .irq_pend_in(irq_pend_in), .irq_high_in(irq_high_in),
      .rd_data_in(rd_data_in), .port_sel_out(port_sel_out), .irq_out(irq_out),
      .wr_out(wr_out), .rd_out(rd_out), .addr_out(addr_out), .wr_data_out(wr_data_out),
      .sdo_out_reg(), .sdo_oe_n_out(oe_n_mon));
   sci_host i_sci_host (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(link.host),
      .start_in(start_in), .byte_in(byte_in), .tx_in(tx_in), .stop_in(stop_in),
      .busy_out(busy_out), .done_out(done_out), .rx_out(rx_out));
   sci_link_properties i_sci_link_properties (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .sck(link.sck), .cs_n(link.cs_n), .serial_data_in(link.serial_data_in),
      .serial_data_out(link.serial_data_out), .sdo_oe_n(link.sdo_oe_n));

   always #12.5 mclk_in = ~mclk_in;

   // register strobe monitor and hang guard
   always @(posedge mclk_in) begin
      cyc++;
      if (wr_out === 1'b1) {wr_cnt, last_wa, last_wd} = {wr_cnt + 1, addr_out, wr_data_out};
      if (rd_out === 1'b1) {rd_cnt, last_ra} = {rd_cnt + 1, addr_out};
      if (cyc == 20000) begin
         miscompares++;
         $display("ERROR %0t run did not finish", $time);
         complete_run();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic do_reset(input logic [3:0] s, input logic [1:0] sel);
      @(posedge mclk_in) {nrst_in, strap} <= {1'b0, s};
      repeat (16) @(posedge mclk_in);
      nrst_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      // straps moved after release must leave the choice alone
      strap <= 4'b1110 ^ s;
      repeat (4) @(posedge mclk_in);
      chk({6'h00, port_sel_out}, {6'h00, sel});
   endtask

   // one framed transfer of tx_q, then strobe counts checked
   task automatic run_frame(input logic [7:0] dw, input logic [7:0] dr);
      int w0;
      int r0;
      w0 = wr_cnt;
      r0 = rd_cnt;
      rx_q = {};
      @(posedge mclk_in) start_in <= 1'b1;
      @(posedge mclk_in) start_in <= 1'b0;
      foreach (tx_q[i]) begin
         @(posedge mclk_in) {byte_in, tx_in} <= {1'b1, tx_q[i]};
         @(posedge mclk_in) byte_in <= 1'b0;
         for (int n = 0; n < 200 && done_out !== 1'b1; n++) @(posedge mclk_in);
         rx_q.push_back(rx_out);
      end
      @(posedge mclk_in) stop_in <= 1'b1;
      @(posedge mclk_in) stop_in <= 1'b0;
      repeat (8) @(posedge mclk_in);
      chk(8'(wr_cnt - w0), dw);
      chk(8'(rd_cnt - r0), dr);
      chk({6'h00, busy_out, oe_n_mon}, 8'h01);
   endtask

   initial begin
      do_reset(4'b1110, 2'b00);
      do_reset(4'b0000, 2'b10);
      tx_q = '{hdr_adad, 8'h12, 8'h9e};
      run_frame(8'h00, 8'h00);
      do_reset(4'b0010, 2'b01);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk_in) {irq_pend_in, irq_high_in} <= {i[0], i[1]};
         repeat (3) @(posedge mclk_in);
         chk({7'h00, irq_out}, {7'h00, i[0] ~^ i[1]});
      end
      tx_q = '{hdr_adad, 8'h12, 8'h9e, 8'h85, 8'h00};
      run_frame(8'h01, 8'h01);
      chk(last_wd, 8'h9e);
      chk(last_ra, 8'h05);
      chk(rx_q[2], 8'hff);
      chk(rx_q[4], 8'hc3);
      tx_q = '{8'h44, 8'h12, 8'h5b};
      run_frame(8'h01, 8'h00);
      chk(last_wa, 8'h92);
      tx_q = '{hdr_adad_il, 8'h81, 8'h82, 8'h00};
      run_frame(8'h00, 8'h02);
      chk(rx_q[3], 8'hc3);
      tx_q = '{8'h4c, 8'h81, 8'h00};
      run_frame(8'h00, 8'h01);
      chk(last_ra, 8'h81);
      tx_q = '{hdr_rdwr, 8'h83, 8'h00, 8'h07, 8'h11, 8'h22};
      run_frame(8'h02, 8'h01);
      chk(rx_q[2], 8'hc3);
      chk(last_wa, 8'h07);
      tx_q = '{8'h45, 8'h07, 8'h66};
      run_frame(8'h01, 8'h00);
      chk(last_wa, 8'h87);
      tx_q = '{hdr_rdwr_il, 8'h83, 8'h07, 8'h33, 8'h44};
      run_frame(8'h02, 8'h01);
      chk(rx_q[2], 8'hc3);
      tx_q = '{8'h4d, 8'h83, 8'h07, 8'h55};
      run_frame(8'h01, 8'h01);
      chk(last_ra, 8'h83);
      tx_q = '{hdr_const, 8'h05, 8'ha1, 8'ha2, 8'ha3};
      run_frame(8'h03, 8'h00);
      chk(last_wd, 8'ha3);
      chk(last_wa, 8'h02);
      tx_q = '{8'h47, 8'h05, 8'ha4};
      run_frame(8'h01, 8'h00);
      chk({7'h00, last_wa[7]}, 8'h01);
      tx_q = '{8'h55, 8'h12, 8'h34};
      run_frame(8'h00, 8'h00);
      complete_run();
   end
endmodule // tb_serial_host_register_port
